// ### design/lcce_pkg.sv
package lcce_pkg;
  // opcode high bytes and the single fixed watchdog opcode
  localparam logic [7:0]  OP_CALL_HI   = 8'h01;
  localparam logic [7:0]  OP_CLRF_HI   = 8'hef;
  localparam logic [7:0]  OP_CLRW_HI   = 8'heb;
  localparam logic [7:0]  OP_CLRACC_HI = 8'hc3;
  localparam logic [23:0] OP_WDT_CLR   = 24'hfe6000;
  // working register indices
  localparam logic [3:0]  REG_W0       = 4'h0;
  localparam logic [3:0]  REG_W8       = 4'h8;
  localparam logic [3:0]  REG_W9       = 4'h9;
  localparam logic [3:0]  REG_W10      = 4'ha;
  localparam logic [3:0]  REG_W11      = 4'hb;
  localparam logic [3:0]  REG_W12      = 4'hc;
  localparam logic [3:0]  REG_W13      = 4'hd;
  localparam logic [3:0]  TGT_LOW_MAX  = 4'hc;
  localparam logic [1:0]  PF_DEST_BASE = 2'h1;
  // increments and the rounding threshold
  localparam logic [23:0] PC_STEP      = 24'h000002;
  localparam logic [15:0] SP_STEP      = 16'h0002;
  localparam logic [15:0] ROUND_HALF   = 16'h8000;
  // prefetch mode low field: 4 means none for W8/W10, indexed for W9/W11
  localparam logic [2:0]  PF_NOMOD     = 3'h0;
  localparam logic [2:0]  PF_INDEX     = 3'h4;
  // write-back selector
  localparam logic [1:0]  WB_DIRECT    = 2'h0;
  localparam logic [1:0]  WB_POSTINC   = 2'h1;
  localparam logic [1:0]  WB_NONE      = 2'h2;
  localparam logic [1:0]  WB_INDIRECT  = 2'h3;
  // call sequencer
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PUSH_HI = 2'b01,
    ST_BRANCH  = 2'b10,
    ST_FILL    = 2'b11
  } lcce_state_e;
endpackage : lcce_pkg

// ### design/lcce_agen.sv
// prefetch address generator: effective address and post-modified pointer
module lcce_agen (
  // decoded prefetch field
  input  wire logic [3:0]  mode,
  // pointer and index register values
  input  wire logic [15:0] base,
  input  wire logic [15:0] index,
  // results
  output logic             rd_en,
  output logic [15:0]      addr,
  output logic             upd_en,
  output logic [15:0]      upd_val
);
  logic [2:0]  neg;   // 8 - code gives 3,2,1 for -6,-4,-2
  logic [15:0] off;   // byte offset magnitude

  // pure decode, no state of its own
  always_comb begin
    neg     = 3'(3'h0 - mode[2:0]);
    off     = 16'h0000;
    rd_en   = 1'b1;
    addr    = base;
    upd_en  = 1'b0;
    upd_val = base;
    if (mode[2:0] == lcce_pkg::PF_INDEX) begin
      // indexed form only exists on the odd pointer
      rd_en = mode[3];
      addr  = base + index;
    end else if (mode[2:0] == lcce_pkg::PF_NOMOD) begin
      rd_en = 1'b1;
    end else if (!mode[2]) begin
      off     = {13'h0000, mode[1:0], 1'b0};
      upd_en  = 1'b1;
      upd_val = base + off;
    end else begin
      off     = {13'h0000, neg[1:0], 1'b0};
      upd_en  = 1'b1;
      upd_val = base - off;
    end
  end
endmodule : lcce_agen

// ### design/lcce_round.sv
// convergent rounding of a 40-bit accumulator to its middle word
module lcce_round (
  // accumulator in
  input  wire logic [39:0] acc,
  // rounded word out
  output logic [15:0]      word
);
  logic up;  // round up when above half, or exactly half and odd

  // ties go to even so repeated stores carry no bias
  always_comb begin
    up   = (acc[15:0] > lcce_pkg::ROUND_HALF) ||
           ((acc[15:0] == lcce_pkg::ROUND_HALF) && acc[16]);
    word = acc[31:16] + {15'h0000, up};
  end
endmodule : lcce_round

// ### design/lcce_exec.sv
module lcce_exec (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // instruction stream
  input  wire logic         instr_valid,
  input  wire logic [23:0]  instr_word,
  input  wire logic [23:0]  pc,
  output logic              busy,
  output logic              illegal_op,
  // core state
  input  wire logic [255:0] w_file,
  input  wire logic         stack_frame_active_flag,
  input  wire logic [39:0]  accumulator_a,
  input  wire logic [39:0]  accumulator_b,
  // program counter
  output logic              pc_load,
  output logic [23:0]       pc_target,
  // system stack
  output logic              stack_wr_en,
  output logic [15:0]       stack_wr_addr,
  output logic [15:0]       stack_top_word,
  output logic              stack_pointer_reg_wr_en,
  output logic [15:0]       stack_pointer_reg_val,
  output logic              stack_frame_active_flag_clr,
  // file and register clear
  output logic              file_clr_en,
  output logic [12:0]       file_clr_addr,
  output logic              file_clr_byte,
  output logic              reg_clr_en,
  output logic [3:0]        reg_clr_idx,
  output logic [2:0]        reg_clr_mode,
  output logic              reg_clr_byte,
  // accumulator clear
  output logic              acc_clr_en,
  output logic              acc_clr_b,
  output logic              acc_a_overflow_flag_clr,
  output logic              acc_a_saturate_flag_clr,
  output logic              acc_b_overflow_flag_clr,
  output logic              acc_b_saturate_flag_clr,
  // x prefetch
  output logic              x_rd_en,
  output logic [15:0]       x_rd_addr,
  output logic [3:0]        x_rd_dest,
  output logic              x_upd_en,
  output logic [3:0]        x_upd_reg,
  output logic [15:0]       x_upd_val,
  // y prefetch
  output logic              y_rd_en,
  output logic [15:0]       y_rd_addr,
  output logic [3:0]        y_rd_dest,
  output logic              y_upd_en,
  output logic [3:0]        y_upd_reg,
  output logic [15:0]       y_upd_val,
  // accumulator write-back
  output logic              wb_en,
  output logic              wb_indirect,
  output logic [15:0]       wb_addr,
  output logic [15:0]       wb_data,
  output logic              wb_upd_en,
  output logic [15:0]       wb_upd_val,
  // watchdog
  output logic              watchdog_clear_op
);
  // whole module state
  typedef struct packed {
    lcce_pkg::lcce_state_e state;
    logic [23:0] ret;        // return address of the pending call
    logic [15:0] sp;         // stack pointer after the first push
    logic        busy;
    logic        illegal;
    logic        pc_load;
    logic [23:0] pc_target;
    logic        stk_en;
    logic [15:0] stk_addr;
    logic [15:0] stk_data;
    logic        sp_en;
    logic [15:0] sp_val;
    logic        sfa_clr;
    logic        f_en;
    logic [12:0] f_addr;
    logic        f_byte;
    logic        r_en;
    logic [3:0]  r_idx;
    logic [2:0]  r_mode;
    logic        r_byte;
    logic        a_en;
    logic        a_b;
    logic        xr_en;
    logic [15:0] xr_addr;
    logic [3:0]  xr_dest;
    logic        xu_en;
    logic [3:0]  xu_reg;
    logic [15:0] xu_val;
    logic        yr_en;
    logic [15:0] yr_addr;
    logic [3:0]  yr_dest;
    logic        yu_en;
    logic [3:0]  yu_reg;
    logic [15:0] yu_val;
    logic        w_en;
    logic        w_ind;
    logic [15:0] w_addr;
    logic [15:0] w_data;
    logic        wu_en;
    logic [15:0] wu_val;
    logic        wdt;
  } lcce_state_s;

  lcce_state_s st;
  lcce_state_s next_st;

  logic        take;                      // instruction accepted this cycle
  logic [3:0]  lo_sel;                    // even register select
  logic [3:0]  hi_sel;                    // odd register select
  logic [3:0]  x_base_sel;                // W8 or W9
  logic [3:0]  y_base_sel;                // W10 or W11
  logic [23:0] ret_addr;                  // current instruction plus 2
  logic [15:0] x_ra, y_ra, x_uv, y_uv;    // agen results
  logic        x_re, y_re, x_ue, y_ue;
  logic [15:0] rnd_a, rnd_b;              // rounded accumulators
  logic [15:0] w13;
  logic [15:0] lo_val;                    // even register of the call pair
  logic [15:0] hi_val;                    // odd register of the call pair

  // register file read by index
  function automatic logic [15:0] default_working_reg(input logic [3:0] idx);
    default_working_reg = w_file[{idx, 4'h0} +: 16];
  endfunction : default_working_reg

  assign take       = instr_valid && (st.state == lcce_pkg::ST_IDLE);
  assign lo_sel     = instr_word[3:0];
  assign hi_sel     = instr_word[14:11];
  assign x_base_sel = instr_word[9] ? lcce_pkg::REG_W9 : lcce_pkg::REG_W8;
  assign y_base_sel = instr_word[5] ? lcce_pkg::REG_W11 : lcce_pkg::REG_W10;
  assign ret_addr   = pc + lcce_pkg::PC_STEP;
  assign w13        = default_working_reg(lcce_pkg::REG_W13);
  // named copies, since a function result cannot be part-selected
  assign lo_val     = default_working_reg(lo_sel);
  assign hi_val     = default_working_reg(hi_sel);

  // prefetch address generators, x and y sides
  lcce_agen u_agen_x (
    .mode    (instr_word[9:6]),
    .base    (default_working_reg(x_base_sel)),
    .index   (default_working_reg(lcce_pkg::REG_W12)),
    .rd_en   (x_re),
    .addr    (x_ra),
    .upd_en  (x_ue),
    .upd_val (x_uv)
  );
  lcce_agen u_agen_y (
    .mode    (instr_word[5:2]),
    .base    (default_working_reg(y_base_sel)),
    .index   (default_working_reg(lcce_pkg::REG_W12)),
    .rd_en   (y_re),
    .addr    (y_ra),
    .upd_en  (y_ue),
    .upd_val (y_uv)
  );
  // one rounder per accumulator keeps the select off the wide path
  lcce_round u_round_a (
    .acc  (accumulator_a),
    .word (rnd_a)
  );
  lcce_round u_round_b (
    .acc  (accumulator_b),
    .word (rnd_b)
  );

  // next-state logic: every strobe is a one-cycle pulse
  always_comb begin
    next_st         = st;
    next_st.illegal = 1'b0;
    next_st.pc_load = 1'b0;
    next_st.stk_en  = 1'b0;
    next_st.sp_en   = 1'b0;
    next_st.sfa_clr = 1'b0;
    next_st.f_en    = 1'b0;
    next_st.r_en    = 1'b0;
    next_st.a_en    = 1'b0;
    next_st.xr_en   = 1'b0;
    next_st.xu_en   = 1'b0;
    next_st.yr_en   = 1'b0;
    next_st.yu_en   = 1'b0;
    next_st.w_en    = 1'b0;
    next_st.wu_en   = 1'b0;
    next_st.wdt     = 1'b0;
    case (st.state)
      lcce_pkg::ST_IDLE: begin
        if (!take) begin
          next_st.busy = 1'b0;
        end else if (instr_word[23:16] == lcce_pkg::OP_CALL_HI && instr_word[15]) begin
          // pair must be even base <= W12 with the odd partner named next
          if (!lo_sel[0] && lo_sel <= lcce_pkg::TGT_LOW_MAX && hi_sel == (lo_sel | 4'h1) &&
              instr_word[10:4] == 7'h00) begin
            next_st.state    = lcce_pkg::ST_PUSH_HI;
            next_st.busy     = 1'b1;
            next_st.ret      = ret_addr;
            next_st.stk_en   = 1'b1;
            next_st.stk_addr = default_working_reg(4'hf);
            next_st.stk_data = {ret_addr[15:1], stack_frame_active_flag};
            next_st.sp       = default_working_reg(4'hf) + lcce_pkg::SP_STEP;
            next_st.sp_en    = 1'b1;
            next_st.sp_val   = default_working_reg(4'hf) + lcce_pkg::SP_STEP;
            // odd bits 15:7 and even bit 0 never reach the target
            next_st.pc_target = {pc[23], hi_val[6:0],
                                 lo_val[15:1], 1'b0};
          end else begin
            next_st.illegal = 1'b1;
          end
        end else if (instr_word[23:16] == lcce_pkg::OP_CLRF_HI && !instr_word[15]) begin
          // D clear targets the default working register
          next_st.f_en   = instr_word[13];
          next_st.f_addr = instr_word[12:0];
          next_st.f_byte = instr_word[14];
          next_st.r_en   = !instr_word[13];
          next_st.r_idx  = lcce_pkg::REG_W0;
          next_st.r_mode = 3'h0;
          next_st.r_byte = instr_word[14];
        end else if (instr_word[23:16] == lcce_pkg::OP_CLRW_HI && !instr_word[15]) begin
          next_st.r_en   = 1'b1;
          next_st.r_idx  = instr_word[10:7];
          next_st.r_mode = instr_word[13:11];
          next_st.r_byte = instr_word[14];
        end else if (instr_word[23:16] == lcce_pkg::OP_CLRACC_HI && !instr_word[14]) begin
          next_st.a_en    = 1'b1;
          next_st.a_b     = instr_word[15];
          next_st.xr_en   = x_re;
          next_st.xr_addr = x_ra;
          next_st.xr_dest = {lcce_pkg::PF_DEST_BASE, instr_word[13:12]};
          next_st.xu_en   = x_ue;
          next_st.xu_reg  = x_base_sel;
          next_st.xu_val  = x_uv;
          next_st.yr_en   = y_re;
          next_st.yr_addr = y_ra;
          next_st.yr_dest = {lcce_pkg::PF_DEST_BASE, instr_word[11:10]};
          next_st.yu_en   = y_ue;
          next_st.yu_reg  = y_base_sel;
          next_st.yu_val  = y_uv;
          // the accumulator not cleared supplies the rounded store
          next_st.w_en   = instr_word[1:0] != lcce_pkg::WB_NONE;
          next_st.w_ind  = instr_word[1:0] != lcce_pkg::WB_DIRECT;
          next_st.w_addr = w13;
          next_st.w_data = instr_word[15] ? rnd_a : rnd_b;
          next_st.wu_en  = instr_word[1:0] == lcce_pkg::WB_POSTINC;
          next_st.wu_val = w13 + lcce_pkg::SP_STEP;
        end else if (instr_word == lcce_pkg::OP_WDT_CLR) begin
          next_st.wdt = 1'b1;
        end else begin
          next_st.illegal = 1'b1;
        end
      end
      lcce_pkg::ST_PUSH_HI: begin
        // second push carries the upper return byte
        next_st.state    = lcce_pkg::ST_BRANCH;
        next_st.stk_en   = 1'b1;
        next_st.stk_addr = st.sp;
        next_st.stk_data = {8'h00, st.ret[23:16]};
        next_st.sp_en    = 1'b1;
        next_st.sp_val   = st.sp + lcce_pkg::SP_STEP;
      end
      lcce_pkg::ST_BRANCH: begin
        // flag cleared only after both words are stacked
        next_st.state   = lcce_pkg::ST_FILL;
        next_st.sfa_clr = 1'b1;
        next_st.pc_load = 1'b1;
      end
      lcce_pkg::ST_FILL: begin
        // slot that the pipeline fills with a no-op
        next_st.state = lcce_pkg::ST_IDLE;
        next_st.busy  = 1'b0;
      end
      default: begin
        next_st.state = lcce_pkg::ST_IDLE;
        next_st.busy  = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign busy                        = st.busy;
  assign illegal_op                  = st.illegal;
  assign pc_load                     = st.pc_load;
  assign pc_target                   = st.pc_target;
  assign stack_wr_en                 = st.stk_en;
  assign stack_wr_addr               = st.stk_addr;
  assign stack_top_word              = st.stk_data;
  assign stack_pointer_reg_wr_en     = st.sp_en;
  assign stack_pointer_reg_val       = st.sp_val;
  assign stack_frame_active_flag_clr = st.sfa_clr;
  assign file_clr_en                 = st.f_en;
  assign file_clr_addr               = st.f_addr;
  assign file_clr_byte               = st.f_byte;
  assign reg_clr_en                  = st.r_en;
  assign reg_clr_idx                 = st.r_idx;
  assign reg_clr_mode                = st.r_mode;
  assign reg_clr_byte                = st.r_byte;
  assign acc_clr_en                  = st.a_en;
  assign acc_clr_b                   = st.a_b;
  assign acc_a_overflow_flag_clr     = st.a_en && !st.a_b;
  assign acc_a_saturate_flag_clr     = st.a_en && !st.a_b;
  assign acc_b_overflow_flag_clr     = st.a_en && st.a_b;
  assign acc_b_saturate_flag_clr     = st.a_en && st.a_b;
  assign x_rd_en                     = st.xr_en;
  assign x_rd_addr                   = st.xr_addr;
  assign x_rd_dest                   = st.xr_dest;
  assign x_upd_en                    = st.xu_en;
  assign x_upd_reg                   = st.xu_reg;
  assign x_upd_val                   = st.xu_val;
  assign y_rd_en                     = st.yr_en;
  assign y_rd_addr                   = st.yr_addr;
  assign y_rd_dest                   = st.yr_dest;
  assign y_upd_en                    = st.yu_en;
  assign y_upd_reg                   = st.yu_reg;
  assign y_upd_val                   = st.yu_val;
  assign wb_en                       = st.w_en;
  assign wb_indirect                 = st.w_ind;
  assign wb_addr                     = st.w_addr;
  assign wb_data                     = st.w_data;
  assign wb_upd_en                   = st.wu_en;
  assign wb_upd_val                  = st.wu_val;
  assign watchdog_clear_op           = st.wdt;

  // checks on the call sequence and the one-cycle clears
  AST_CALL_SEQ: assert property (@(posedge clk) disable iff (sys_rst)
    (st.state == lcce_pkg::ST_PUSH_HI) |-> st.stk_en ##1 st.stk_en ##1 (st.pc_load && st.sfa_clr))
    else $error("call sequence out of order");
  AST_CALL_PAIR: assert property (@(posedge clk) disable iff (sys_rst)
    (take && instr_word[23:15] == 9'h003 && (instr_word[0] || instr_word[3:0] > 4'hc))
    |=> illegal_op && !stack_wr_en)
    else $error("bad register pair accepted");
  AST_PC_EVEN: assert property (@(posedge clk) disable iff (sys_rst)
    pc_load |-> !pc_target[0] && $past(stack_wr_en, 1) && $past(stack_wr_en, 2))
    else $error("branch target odd or not stacked");
  AST_PC_TOP: assert property (@(posedge clk) disable iff (sys_rst)
    (st.state == lcce_pkg::ST_PUSH_HI) |-> ##2 pc_target[23] == $past(pc[23], 3))
    else $error("pc bit 23 changed by call");
  AST_STACK_HI: assert property (@(posedge clk) disable iff (sys_rst)
    (st.state == lcce_pkg::ST_BRANCH) |-> stack_top_word == {8'h00, st.ret[23:16]}
      && stack_wr_addr == $past(stack_wr_addr) + 16'h0002)
    else $error("upper return word wrong");
  AST_ACC_FLAGS: assert property (@(posedge clk) disable iff (sys_rst)
    (take && instr_word[23:14] == {8'hc3, 2'b10}) |=> acc_clr_en && acc_b_overflow_flag_clr
      && acc_b_saturate_flag_clr && !acc_a_overflow_flag_clr && !busy)
    else $error("accumulator clear flags wrong");
  AST_WB_SRC: assert property (@(posedge clk) disable iff (sys_rst)
    (take && instr_word[23:14] == {8'hc3, 2'b00} && instr_word[1:0] == 2'h0)
    |=> wb_en && !wb_indirect && wb_data == $past(rnd_b))
    else $error("write-back source wrong");
  AST_PF_DEST: assert property (@(posedge clk) disable iff (sys_rst)
    x_rd_en |-> x_rd_dest[3:2] == 2'b01 && $past(instr_word[13:12]) == x_rd_dest[1:0])
    else $error("prefetch destination wrong");
  AST_FILE_CLR: assert property (@(posedge clk) disable iff (sys_rst)
    (take && instr_word[23:15] == {8'hef, 1'b0} && instr_word[13]) |=> file_clr_en && !reg_clr_en
      && file_clr_addr == $past(instr_word[12:0]) && file_clr_byte == $past(instr_word[14])
      ##1 (!file_clr_en || $past(take)))
    else $error("file clear wrong");
  AST_WDT: assert property (@(posedge clk) disable iff (sys_rst)
    (take && instr_word == 24'hfe6000) |=> watchdog_clear_op ##1 (!watchdog_clear_op || $past(take)))
    else $error("watchdog clear not one pulse");
endmodule : lcce_exec

// ### sim/test_long_call_and_clear_exec.sv
module test_long_call_and_clear_exec;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, all but the clock driven by non-blocking assignment at the rising edge or 1 ns after it
  logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, stack_frame_active_flag = 1'b0;
  logic [23:0] instr_word = 24'h000000, pc = 24'h000000;
  logic [255:0] w_file = '0;
  logic [39:0] accumulator_a = 40'h0000000000, accumulator_b = 40'h0000000000;
  // design outputs
  logic busy, illegal_op, pc_load, stack_wr_en, stack_pointer_reg_wr_en, stack_frame_active_flag_clr;
  logic file_clr_en, file_clr_byte, reg_clr_en, reg_clr_byte, acc_clr_en, acc_clr_b, watchdog_clear_op;
  logic acc_a_overflow_flag_clr, acc_a_saturate_flag_clr, acc_b_overflow_flag_clr, acc_b_saturate_flag_clr;
  logic x_rd_en, x_upd_en, y_rd_en, y_upd_en, wb_en, wb_indirect, wb_upd_en;
  logic [23:0] pc_target;
  logic [15:0] stack_wr_addr, stack_top_word, stack_pointer_reg_val, x_rd_addr, x_upd_val, y_rd_addr, y_upd_val;
  logic [15:0] wb_addr, wb_data, wb_upd_val;
  logic [12:0] file_clr_addr;
  logic [3:0]  reg_clr_idx, x_rd_dest, x_upd_reg, y_rd_dest, y_upd_reg;
  logic [2:0]  reg_clr_mode;
  // bookkeeping
  int bad_count = 0, n_tests = 0, cycles = 0;

  lcce_exec dut_u (.clk, .sys_rst, .instr_valid, .instr_word, .pc, .busy, .illegal_op, .w_file,
    .stack_frame_active_flag, .accumulator_a, .accumulator_b, .pc_load, .pc_target, .stack_wr_en,
    .stack_wr_addr, .stack_top_word, .stack_pointer_reg_wr_en, .stack_pointer_reg_val,
    .stack_frame_active_flag_clr, .file_clr_en, .file_clr_addr, .file_clr_byte, .reg_clr_en, .reg_clr_idx,
    .reg_clr_mode, .reg_clr_byte, .acc_clr_en, .acc_clr_b, .acc_a_overflow_flag_clr, .acc_a_saturate_flag_clr,
    .acc_b_overflow_flag_clr, .acc_b_saturate_flag_clr, .x_rd_en, .x_rd_addr, .x_rd_dest, .x_upd_en,
    .x_upd_reg, .x_upd_val, .y_rd_en, .y_rd_addr, .y_rd_dest, .y_upd_en, .y_upd_reg, .y_upd_val, .wb_en,
    .wb_indirect, .wb_addr, .wb_data, .wb_upd_en, .wb_upd_val, .watchdog_clear_op);

  // 100 MHz clock
  always #5 clk = ~clk;

  // hang guard: the whole run needs well under a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // one comparison; ok is a case-equality result so unknowns fail
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // one edge: present a word, then look once the edge's updates have landed
  task automatic step(input logic v, input logic [23:0] w);
    @(posedge clk);
    instr_valid <= v;
    instr_word  <= w;
    #1;
  endtask : step

  // working register write, lands in this time step, before the next edge
  task automatic setw(input int n, input logic [15:0] v);
    w_file[n*16 +: 16] <= v;
  endtask : setw

  // long call; watchdog words offered while busy must be dropped
  task automatic call_seq(input logic [23:0] w, sp_lo, input logic [15:0] lo, hi, input logic [23:0] tgt);
    step(1'b1, w);
    step(1'b1, lcce_pkg::OP_WDT_CLR);
    chk(stack_wr_en === 1'b1 && stack_wr_addr === sp_lo[15:0] && stack_top_word === lo && busy === 1'b1
        && stack_pointer_reg_wr_en === 1'b1
        && stack_pointer_reg_val === sp_lo[15:0] + 16'h0002, "first push");
    step(1'b1, lcce_pkg::OP_WDT_CLR);
    chk(stack_wr_en === 1'b1 && stack_wr_addr === sp_lo[15:0] + 16'h0002 && stack_top_word === hi
        && stack_pointer_reg_val === sp_lo[15:0] + 16'h0004, "second push");
    step(1'b0, 24'h000000);
    chk(pc_load === 1'b1 && pc_target === tgt && stack_frame_active_flag_clr === 1'b1, "branch");
    step(1'b0, 24'h000000);
    chk(busy === 1'b0 && pc_load === 1'b0 && watchdog_clear_op === 1'b0, "call end or busy word taken");
  endtask : call_seq

  task automatic t_calls();
    logic [23:0] bad_words [3];
    bad_words = '{24'h01f80e, 24'h01b804, 24'hffffff};
    // plain case with W4/W5, flag low
    setw(4, 16'h6844); setw(5, 16'h0002); setw(15, 16'ha268); pc <= 24'h026000;
    call_seq(24'h01a804, 24'h00a268, 16'h6002, 16'h0002, 24'h026844);
    // top pair, odd low bit, junk high bits, bit 23 set, flag high
    setw(12, 16'h1235); setw(13, 16'hff83); setw(15, 16'h9004);
    pc <= 24'h800ffe;
    stack_frame_active_flag <= 1'b1;
    call_seq(24'h01e80c, 24'h009004, 16'h1001, 16'h0080, 24'h831234);
    // register beyond W12, mismatched odd register, unknown word
    foreach (bad_words[i]) begin
      step(1'b1, bad_words[i]);
      step(1'b0, 24'h000000);
      chk(illegal_op === 1'b1 && pc_load === 1'b0 && stack_wr_en === 1'b0 && busy === 1'b0, "bad word");
    end
  endtask : t_calls

  // four back-to-back accumulator clears
  task automatic t_acc();
    setw(8, 16'h2000); setw(9, 16'h5000); setw(10, 16'h3000); setw(11, 16'h6000);
    setw(12, 16'h0010); setw(13, 16'h4000);
    accumulator_a <= 40'h0000672345;
    accumulator_b <= 40'h0054203bdd;
    step(1'b1, 24'hc30050);
    step(1'b1, 24'hc3ac45);
    accumulator_b <= 40'h0000678000;
    chk(acc_clr_en === 1'b1 && acc_clr_b === 1'b0 && acc_a_overflow_flag_clr === 1'b1
        && acc_a_saturate_flag_clr === 1'b1 && acc_b_overflow_flag_clr === 1'b0, "clear a");
    chk(x_rd_en === 1'b1 && x_rd_addr === 16'h2000 && x_rd_dest === 4'h4 && x_upd_en === 1'b1
        && x_upd_reg === 4'h8 && x_upd_val === 16'h2002 && y_rd_en === 1'b0, "x prefetch");
    chk(wb_en === 1'b1 && wb_indirect === 1'b0 && wb_data === 16'h5420 && wb_upd_en === 1'b0, "wb direct");
    step(1'b1, 24'hc31372);
    chk(acc_clr_b === 1'b1 && acc_b_overflow_flag_clr === 1'b1 && acc_b_saturate_flag_clr === 1'b1
        && acc_a_overflow_flag_clr === 1'b0, "clear b");
    chk(x_rd_dest === 4'h6 && y_rd_en === 1'b1 && y_rd_addr === 16'h3000 && y_rd_dest === 4'h7
        && y_upd_reg === 4'ha && y_upd_val === 16'h3002, "y prefetch");
    chk(wb_en === 1'b1 && wb_indirect === 1'b1 && wb_addr === 16'h4000 && wb_data === 16'h0067
        && wb_upd_en === 1'b1 && wb_upd_val === 16'h4002, "wb indirect");
    step(1'b1, 24'hc3883f);
    chk(x_rd_addr === 16'h5000 && x_rd_dest === 4'h5 && x_upd_reg === 4'h9 && x_upd_val === 16'h4ffa
        && y_rd_addr === 16'h6010 && y_rd_dest === 4'h4 && y_upd_en === 1'b0, "minus six and index");
    chk(wb_en === 1'b0 && wb_data === 16'h0068, "no write-back, tie rounds to even");
    step(1'b0, 24'h000000);
    chk(acc_clr_b === 1'b1 && x_rd_en === 1'b1 && x_rd_addr === 16'h2000 && x_rd_dest === 4'h4
        && x_upd_en === 1'b0 && y_rd_en === 1'b1 && y_rd_addr === 16'h6000 && y_rd_dest === 4'h6
        && y_upd_en === 1'b1 && y_upd_reg === 4'hb && y_upd_val === 16'h5ffe, "no modify, minus two");
    chk(wb_en === 1'b1 && wb_indirect === 1'b1 && wb_addr === 16'h4000 && wb_data === 16'h0067
        && wb_upd_en === 1'b0, "wb indirect, no modify");
    step(1'b0, 24'h000000);
    chk(acc_clr_en === 1'b0 && x_rd_en === 1'b0 && wb_en === 1'b0, "one cycle only");
  endtask : t_acc

  // register clears and the watchdog, back to back
  task automatic t_clears();
    step(1'b1, 24'hef6200);
    step(1'b1, 24'hef0000);
    chk(file_clr_en === 1'b1 && file_clr_addr === 13'h0200 && file_clr_byte === 1'b1, "clear file");
    step(1'b1, 24'heb4100);
    chk(reg_clr_en === 1'b1 && reg_clr_idx === 4'h0 && reg_clr_byte === 1'b0 && file_clr_en === 1'b0, "clear w0");
    step(1'b1, 24'heb1800);
    chk(reg_clr_idx === 4'h2 && reg_clr_mode === 3'h0 && reg_clr_byte === 1'b1, "clear w2 byte");
    step(1'b1, lcce_pkg::OP_WDT_CLR);
    chk(reg_clr_idx === 4'h0 && reg_clr_mode === 3'h3 && reg_clr_byte === 1'b0, "clear post-inc");
    step(1'b0, 24'h000000);
    chk(watchdog_clear_op === 1'b1 && reg_clr_en === 1'b0 && acc_a_overflow_flag_clr === 1'b0
        && acc_b_saturate_flag_clr === 1'b0, "watchdog");
    step(1'b0, 24'h000000);
    chk(watchdog_clear_op === 1'b0, "watchdog pulse");
  endtask : t_clears

  // main sequence: reset for eight edges, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(busy === 1'b0 && pc_load === 1'b0 && illegal_op === 1'b0, "reset state");
    t_calls();
    t_acc();
    t_clears();
    summarize();
  end
endmodule : test_long_call_and_clear_exec
